//--- design/pim_pkg.sv
package pim_pkg;

  localparam int CODE_W = 12;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam logic [11:0] SPD_CW_ZERO = 12'h800;
  localparam logic [11:0] SPD_CCW_ZERO = 12'h7ff;
  localparam int SPD_SPAN = 2047;
  localparam int SPD_MAX_RPM = 2400;
  localparam int CODE_FULL = 4095;

  // Bus voltage in units of 10 mV; full code is 73.26 V
  localparam int BUS_FULL_CV = 7326;
  localparam int OV_LIMIT_V = 60;
  localparam int UV_LIMIT_V = 8;
  localparam logic [15:0] OV_LIMIT_CV = 16'(OV_LIMIT_V * 100);
  localparam logic [15:0] UV_LIMIT_CV = 16'(UV_LIMIT_V * 100);

  // Phase current in mA; codes span -8.25 A to +8.25 A
  localparam int CUR_FULL_MA = 8250;

  // Modulation ratio fixed point fraction bits
  localparam int MOD_Q = 12;
  localparam int DIV_W = 32;

  localparam int CLK_HZ = 25_000_000;
  localparam int SPEED_PERIOD_US = 500;
  localparam int SPEED_TICK_CYC = SPEED_PERIOD_US * (CLK_HZ / 1_000_000);

  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SPEED = 8'h08;
  localparam logic [7:0] REG_BUS_V = 8'h0c;
  localparam logic [7:0] REG_CUR_U = 8'h10;
  localparam logic [7:0] REG_CUR_V = 8'h14;
  localparam logic [7:0] REG_CUR_W = 8'h18;
  localparam logic [7:0] REG_MOD_RATIO = 8'h1c;

  localparam int CTRL_SVM_BIT = 0;
  localparam int CTRL_TWO_SHUNT_BIT = 1;
  localparam int CTRL_RESET_EVT_BIT = 2;
  localparam logic CTRL_SVM_RST = 1'b0;
  localparam logic CTRL_TWO_SHUNT_RST = 1'b0;

  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_OC_BIT = 2;
  localparam int STAT_OV_BIT = 3;
  localparam int STAT_UV_BIT = 4;
  localparam int STAT_PWM_EN_BIT = 5;
  localparam int SPEED_DIR_BIT = 16;

  typedef enum logic [1:0] {
    MODE_INACTIVE,
    MODE_ACTIVE,
    MODE_ERROR
  } pim_mode_e;

endpackage

//--- design/pim_divider.sv
`timescale 1ns/1ps
module pim_divider #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic done,
  output logic [W-1:0] quo
);

  localparam int CW = $clog2(W + 1);

  logic [W-1:0] rem_reg;
  logic [W-1:0] num_reg;
  logic [W-1:0] den_reg;
  logic [CW-1:0] cnt_reg;
  logic [W:0] trial;

  initial
  begin
    if (W < 2)
      $error("pim_divider width too small");
  end

  assign trial = {rem_reg, num_reg[W-1]} - {1'b0, den_reg};

  // Restoring division, one quotient bit per cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rem_reg <= '0;
      num_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      quo <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        rem_reg <= '0;
        num_reg <= num;
        den_reg <= den;
        cnt_reg <= CW'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (!trial[W])
          rem_reg <= trial[W-1:0];
        else
          rem_reg <= {rem_reg[W-2:0], num_reg[W-1]};
        num_reg <= {num_reg[W-2:0], ~trial[W]};
        cnt_reg <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
          quo <= {num_reg[W-2:0], ~trial[W]};
        end
      end
    end
  end

endmodule

//--- design/pim_ctrl.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
// Function
// RQ1: Switch level high runs, low stops drive
// RQ2: CW codes 800h..fffh map 0..2400 rpm
// RQ3: CCW codes 7ffh..000h map 0..2400 rpm
// RQ4: Bus code scales linearly to 73.26 V
// RQ5: Bus voltage feeds ratio and limit checks
// RQ6: Phase code scales to -8.25..+8.25 A
// RQ7: Option: derive V current from U, W
// RQ8: Register bit selects sine or space vector
// RQ9: Sine ratio is reference over bus voltage
// RQ10: Space vector subtracts half of max+min
// RQ11: Offset shrinks peak, keeps line voltages
// RQ12: Space vector ratio uses offset waves
// RQ13: Three modes: inactive, active, error
// RQ14: Mode changes only on an event
// RQ15: Overcurrent event served first, level 0
// RQ16: Conversion before speed tick servicing
// RQ17: Detected fault raises the error event
// RQ18: Emergency stop cuts outputs immediately
// RQ19: Overvoltage above 60 V per period
// RQ20: Undervoltage below 8 V per period
// RQ21: Waves recomputed then compare values loaded
// RQ22: Error mode holds outputs off until reset
module pim_ctrl #(
  parameter int SPEED_TICK_CYCLES = pim_pkg::SPEED_TICK_CYC,
  parameter int VW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_stop_switch,
  input wire logic [11:0] speed_reference_pot,
  input wire logic [11:0] bus_volt_code,
  input wire logic [11:0] cur_u_code,
  input wire logic [11:0] cur_v_code,
  input wire logic [11:0] cur_w_code,
  input wire logic conversion_done_irq,
  input wire logic output_disable_event,
  input wire logic signed [VW-1:0] vcmd_u,
  input wire logic signed [VW-1:0] vcmd_v,
  input wire logic signed [VW-1:0] vcmd_w,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic pwm_out_en,
  output logic compare_load,
  output logic signed [VW-1:0] mod_wave_u,
  output logic signed [VW-1:0] mod_wave_v,
  output logic signed [VW-1:0] mod_wave_w,
  output logic [15:0] mod_ratio,
  output logic speed_tick_irq,
  output logic [11:0] speed_cmd_rpm,
  output logic speed_dir_ccw,
  output logic [1:0] system_mode
);

  localparam int TW = $clog2(SPEED_TICK_CYCLES + 1);
  localparam int DW = pim_pkg::DIV_W;

  initial
  begin
    if (SPEED_TICK_CYCLES < 2)
      $error("speed tick period too short");
    if (VW < 8 || VW > 18)
      $error("voltage command width unsupported");
  end

  function automatic logic signed [15:0] cur_ma(input logic [11:0] code);
    logic [31:0] scaled;
    scaled = (32'(code) * 32'(2 * pim_pkg::CUR_FULL_MA))
             / 32'(pim_pkg::CODE_FULL);
    cur_ma = 16'(signed'(scaled) - pim_pkg::CUR_FULL_MA); // RQ6
  endfunction

  function automatic logic [VW:0] mag(input logic signed [VW:0] v);
    mag = v[VW] ? -v : v;
  endfunction

  pim_pkg::pim_mode_e mode_reg;
  logic svm_sel_reg;
  logic two_shunt_reg;
  logic reset_evt;
  logic fault_oc_reg;
  logic fault_ov_reg;
  logic fault_uv_reg;
  logic conv_pend_reg;
  logic spd_pend_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic conv_serve;
  logic spd_serve;
  logic [15:0] bus_cv_reg;
  logic [15:0] bus_cv_next;
  logic ov_now;
  logic uv_now;
  logic fault_now;
  logic signed [15:0] cur_u_reg;
  logic signed [15:0] cur_v_reg;
  logic signed [15:0] cur_w_reg;
  logic signed [VW:0] vu;
  logic signed [VW:0] vv;
  logic signed [VW:0] vw;
  logic signed [VW:0] vmax;
  logic signed [VW:0] vmin;
  logic signed [VW:0] mid;
  logic signed [VW:0] offset;
  logic signed [VW:0] wu;
  logic signed [VW:0] wv;
  logic signed [VW:0] wvv;
  logic [VW:0] peak;
  logic signed [VW-1:0] wave_u_reg;
  logic signed [VW-1:0] wave_v_reg;
  logic signed [VW-1:0] wave_w_reg;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [DW-1:0] div_quo;
  logic [DW-1:0] div_num;
  logic [DW-1:0] div_den;
  // Event arbitration: conversion pre-empts speed tick
  assign conv_serve = conv_pend_reg && !div_busy; // RQ16
  assign spd_serve = spd_pend_reg && !conv_pend_reg && !div_busy; // RQ16

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_reg <= '0;
      speed_tick_irq <= 1'b0;
    end
    else if (tick_cnt_reg == TW'(SPEED_TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= '0;
      speed_tick_irq <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
      speed_tick_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      conv_pend_reg <= 1'b0;
      spd_pend_reg <= 1'b0;
    end
    else
    begin
      if (conversion_done_irq)
        conv_pend_reg <= 1'b1;
      else if (conv_serve)
        conv_pend_reg <= 1'b0;
      if (speed_tick_irq)
        spd_pend_reg <= 1'b1;
      else if (spd_serve)
        spd_pend_reg <= 1'b0;
    end
  end

  // Bus voltage and limit checks, once per current period
  assign bus_cv_next = 16'((32'(bus_volt_code) * 32'(pim_pkg::BUS_FULL_CV))
                           / 32'(pim_pkg::CODE_FULL)); // RQ4
  assign ov_now = conv_serve && (bus_cv_next > pim_pkg::OV_LIMIT_CV); // RQ19
  assign uv_now = conv_serve && (bus_cv_next < pim_pkg::UV_LIMIT_CV); // RQ20
  assign fault_now = output_disable_event || ov_now || uv_now; // RQ17 RQ5

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_cv_reg <= '0;
      cur_u_reg <= '0;
      cur_v_reg <= '0;
      cur_w_reg <= '0;
    end
    else if (conv_serve)
    begin
      bus_cv_reg <= bus_cv_next;
      cur_u_reg <= cur_ma(cur_u_code);
      cur_w_reg <= cur_ma(cur_w_code);
      if (two_shunt_reg)
        cur_v_reg <= 16'(-(cur_ma(cur_u_code) + cur_ma(cur_w_code))); // RQ7
      else
        cur_v_reg <= cur_ma(cur_v_code);
    end
  end

  // Sticky fault flags; a new fault wins over the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_oc_reg <= 1'b0;
      fault_ov_reg <= 1'b0;
      fault_uv_reg <= 1'b0;
    end
    else
    begin
      if (output_disable_event)
        fault_oc_reg <= 1'b1; // RQ15
      else if (reset_evt)
        fault_oc_reg <= 1'b0;
      if (ov_now)
        fault_ov_reg <= 1'b1;
      else if (reset_evt)
        fault_ov_reg <= 1'b0;
      if (uv_now)
        fault_uv_reg <= 1'b1;
      else if (reset_evt)
        fault_uv_reg <= 1'b0;
    end
  end

  // System mode machine
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_reg <= pim_pkg::MODE_INACTIVE;
    else
    begin
      case (mode_reg) // RQ13 RQ14
        pim_pkg::MODE_INACTIVE:
          if (fault_now)
            mode_reg <= pim_pkg::MODE_ERROR; // RQ17
          else if (start_stop_switch)
            mode_reg <= pim_pkg::MODE_ACTIVE; // RQ1
        pim_pkg::MODE_ACTIVE:
          if (fault_now)
            mode_reg <= pim_pkg::MODE_ERROR; // RQ17 RQ15
          else if (!start_stop_switch)
            mode_reg <= pim_pkg::MODE_INACTIVE; // RQ1
        pim_pkg::MODE_ERROR:
          if (reset_evt && !fault_now)
            mode_reg <= pim_pkg::MODE_INACTIVE; // RQ22
        default:
          mode_reg <= pim_pkg::MODE_ERROR;
      endcase
    end
  end

  assign system_mode = mode_reg;
  // Emergency stop acts combinationally on the enable
  assign pwm_out_en = (mode_reg == pim_pkg::MODE_ACTIVE)
                      && !output_disable_event; // RQ18 RQ22 RQ5

  // Modulation waves
  assign vu = (VW+1)'(vcmd_u);
  assign vv = (VW+1)'(vcmd_v);
  assign vw = (VW+1)'(vcmd_w);

  always_comb
  begin
    vmax = vu;
    vmin = vu;
    if (vv > vmax)
      vmax = vv;
    if (vw > vmax)
      vmax = vw;
    if (vv < vmin)
      vmin = vv;
    if (vw < vmin)
      vmin = vw;
  end

  // Subtracting the mid value lifts utilisation to the full bus
  // Sum taken one bit wider so extreme commands cannot wrap
  assign mid = (VW+1)'(((VW+2)'(vmax) + (VW+2)'(vmin)) >>> 1); // RQ10
  assign offset = svm_sel_reg ? mid : '0; // RQ10 RQ11 RQ8
  assign wu = vu - offset; // RQ10
  assign wv = vv - offset;
  assign wvv = vw - offset;

  always_comb
  begin
    peak = mag(wu);
    if (mag(wv) > peak)
      peak = mag(wv);
    if (mag(wvv) > peak)
      peak = mag(wvv);
  end

  // Ratio = peak wave / bus voltage, in Q12
  assign div_start = conv_serve; // RQ21
  assign div_num = DW'(peak) << pim_pkg::MOD_Q; // RQ9 RQ12
  assign div_den = DW'(bus_cv_next); // RQ5

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wave_u_reg <= '0;
      wave_v_reg <= '0;
      wave_w_reg <= '0;
    end
    else if (conv_serve)
    begin
      wave_u_reg <= VW'(wu); // RQ21
      wave_v_reg <= VW'(wv);
      wave_w_reg <= VW'(wvv);
    end
  end

  pim_divider #(
    .W(DW)
  ) u_div (
    .clk(clk),
    .rst(rst),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .busy(div_busy),
    .done(div_done),
    .quo(div_quo)
  );

  // Compare values loaded only after the ratio is ready
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mod_wave_u <= '0;
      mod_wave_v <= '0;
      mod_wave_w <= '0;
      mod_ratio <= '0;
      compare_load <= 1'b0;
    end
    else
    begin
      compare_load <= div_done; // RQ21
      if (div_done)
      begin
        mod_wave_u <= wave_u_reg;
        mod_wave_v <= wave_v_reg;
        mod_wave_w <= wave_w_reg;
        if (div_quo[DW-1:16] != '0)
          mod_ratio <= 16'hffff;
        else
          mod_ratio <= div_quo[15:0]; // RQ9 RQ12
      end
    end
  end

  // Speed command updated on each served speed tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      speed_cmd_rpm <= '0;
      speed_dir_ccw <= 1'b0;
    end
    else if (spd_serve)
    begin
      if (speed_reference_pot >= pim_pkg::SPD_CW_ZERO)
      begin
        speed_dir_ccw <= 1'b0;
        speed_cmd_rpm <= 12'((32'(speed_reference_pot - pim_pkg::SPD_CW_ZERO)
          * 32'(pim_pkg::SPD_MAX_RPM)) / 32'(pim_pkg::SPD_SPAN)); // RQ2
      end
      else
      begin
        speed_dir_ccw <= 1'b1;
        speed_cmd_rpm <= 12'((32'(pim_pkg::SPD_CCW_ZERO - speed_reference_pot)
          * 32'(pim_pkg::SPD_MAX_RPM)) / 32'(pim_pkg::SPD_SPAN)); // RQ3
      end
    end
  end

  // Register port
  assign reset_evt = reg_wr && (reg_addr == pim_pkg::REG_CTRL)
                     && reg_wdata[pim_pkg::CTRL_RESET_EVT_BIT]; // RQ22

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      svm_sel_reg <= pim_pkg::CTRL_SVM_RST;
      two_shunt_reg <= pim_pkg::CTRL_TWO_SHUNT_RST;
    end
    else if (reg_wr && reg_addr == pim_pkg::REG_CTRL)
    begin
      svm_sel_reg <= reg_wdata[pim_pkg::CTRL_SVM_BIT]; // RQ8
      two_shunt_reg <= reg_wdata[pim_pkg::CTRL_TWO_SHUNT_BIT]; // RQ7
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      reg_rdata <= '0;
      case (reg_addr)
        pim_pkg::REG_CTRL:
        begin
          reg_rdata[pim_pkg::CTRL_SVM_BIT] <= svm_sel_reg;
          reg_rdata[pim_pkg::CTRL_TWO_SHUNT_BIT] <= two_shunt_reg;
        end
        pim_pkg::REG_STATUS:
        begin
          reg_rdata[pim_pkg::STAT_MODE_LSB +: 2] <= mode_reg;
          reg_rdata[pim_pkg::STAT_OC_BIT] <= fault_oc_reg;
          reg_rdata[pim_pkg::STAT_OV_BIT] <= fault_ov_reg;
          reg_rdata[pim_pkg::STAT_UV_BIT] <= fault_uv_reg;
          reg_rdata[pim_pkg::STAT_PWM_EN_BIT] <= pwm_out_en;
        end
        pim_pkg::REG_SPEED:
        begin
          reg_rdata[11:0] <= speed_cmd_rpm;
          reg_rdata[pim_pkg::SPEED_DIR_BIT] <= speed_dir_ccw;
        end
        pim_pkg::REG_BUS_V:
          reg_rdata[15:0] <= bus_cv_reg;
        pim_pkg::REG_CUR_U:
          reg_rdata[15:0] <= cur_u_reg;
        pim_pkg::REG_CUR_V:
          reg_rdata[15:0] <= cur_v_reg;
        pim_pkg::REG_CUR_W:
          reg_rdata[15:0] <= cur_w_reg;
        pim_pkg::REG_MOD_RATIO:
          reg_rdata[15:0] <= mod_ratio;
        default:
          reg_rdata <= '0;
      endcase
    end
  end

endmodule

//--- dv/pim_inverter_model.sv
`timescale 1ns/1ps
module pim_inverter_model #(
  parameter int CONV_CYCLES = 80
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_en,
  input wire logic pwm_out_en,
  input wire logic [11:0] sense_bus,
  input wire logic [11:0] sense_u,
  input wire logic [11:0] sense_v,
  input wire logic [11:0] sense_w,
  output logic [11:0] bus_volt_code,
  output logic [11:0] cur_u_code,
  output logic [11:0] cur_v_code,
  output logic [11:0] cur_w_code,
  output logic conversion_done_irq
);
  logic [7:0] cnt;
  logic last;

  assign last = cnt == 8'(CONV_CYCLES - 1);

  // Codes latch with the end-of-scan pulse and hold until the next scan
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 8'h00;
      conversion_done_irq <= 1'b0;
      bus_volt_code <= 12'h000;
      cur_u_code <= 12'h800;
      cur_v_code <= 12'h800;
      cur_w_code <= 12'h800;
    end
    else
    begin
      cnt <= last ? 8'h00 : cnt + 8'h01;
      conversion_done_irq <= conv_en && last;
      if (last)
      begin
        bus_volt_code <= sense_bus;
        // No phase current flows while the bridge is disabled
        cur_u_code <= pwm_out_en ? sense_u : 12'h800;
        cur_v_code <= pwm_out_en ? sense_v : 12'h800;
        cur_w_code <= pwm_out_en ? sense_w : 12'h800;
      end
    end
  end
endmodule

//--- dv/pim_ctrl_properties.sv
`timescale 1ns/1ps
module pim_ctrl_properties #(
  parameter int SPEED_TICK_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start_stop_switch,
  input wire logic conversion_done_irq,
  input wire logic output_disable_event,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic pwm_out_en,
  input wire logic compare_load,
  input wire logic signed [15:0] mod_wave_u,
  input wire logic [15:0] mod_ratio,
  input wire logic speed_tick_irq,
  input wire logic [1:0] system_mode
);
  logic [31:0] since_tick;
  logic tick_seen;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      since_tick <= 32'h0;
      tick_seen <= 1'b0;
    end
    else
    begin
      since_tick <= speed_tick_irq ? 32'h0 : since_tick + 32'h1;
      tick_seen <= tick_seen | speed_tick_irq;
    end
  end

  pwm_gate_a: assert property (pwm_out_en |-> system_mode == 2'h1
    && !output_disable_event) else $error("pwm enabled out of mode");
  odis_err_a: assert property (output_disable_event |=> system_mode == 2'h2)
    else $error("emergency stop missed");
  start_run_a: assert property (system_mode == 2'h0 && start_stop_switch
    && !output_disable_event |=> system_mode inside {2'h1, 2'h2})
    else $error("no start on switch");
  stop_run_a: assert property (system_mode == 2'h1 && !start_stop_switch
    && !output_disable_event |=> system_mode inside {2'h0, 2'h2})
    else $error("no stop on switch");
  error_hold_a: assert property (system_mode == 2'h2 && !reg_wr
    && !$past(reg_wr) |=> system_mode == 2'h2) else $error("error left");
  mode_legal_a: assert property (system_mode != 2'h3)
    else $error("illegal mode");
  conv_load_a: assert property ($rose(conversion_done_irq)
    |-> ##[2:45] compare_load) else $error("no compare load");
  wave_hold_a: assert property (!compare_load |-> $stable(mod_wave_u)
    && $stable(mod_ratio)) else $error("wave moved without load");
  tick_period_a: assert property (speed_tick_irq && tick_seen
    |-> since_tick == 32'(SPEED_TICK_CYCLES - 1)) else $error("tick period");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved");

  cover property (system_mode == 2'h1 && compare_load);
  cover property ($rose(system_mode == 2'h2));
  cover property (speed_tick_irq && tick_seen);
endmodule

bind pim_ctrl pim_ctrl_properties #(.SPEED_TICK_CYCLES(SPEED_TICK_CYCLES)) u_props (
  .clk(clk), .rst(rst), .start_stop_switch(start_stop_switch),
  .conversion_done_irq(conversion_done_irq), .reg_wr(reg_wr),
  .output_disable_event(output_disable_event), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pwm_out_en(pwm_out_en), .mod_ratio(mod_ratio),
  .compare_load(compare_load), .mod_wave_u(mod_wave_u),
  .speed_tick_irq(speed_tick_irq), .system_mode(system_mode));

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, start_stop_switch = 0, output_disable_event = 0;
  logic reg_wr = 0, reg_rd = 0, conv_en = 0, conversion_done_irq;
  logic [11:0] speed_reference_pot = 0, s_bus = 12'd2000, s_u = 0, s_v = 0;
  logic [11:0] s_w = 0, bus_volt_code, cur_u_code, cur_v_code, cur_w_code;
  logic signed [15:0] vcmd_u = 0, vcmd_v = 0, vcmd_w = 0;
  logic signed [15:0] mod_wave_u, mod_wave_v, mod_wave_w;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, rd_val;
  logic pwm_out_en, compare_load, speed_tick_irq, speed_dir_ccw;
  logic [15:0] mod_ratio;
  logic [11:0] speed_cmd_rpm;
  logic [1:0] system_mode;
  int num_errors = 0, samples_checked = 0;

  always #20 clk = ~clk;

  pim_inverter_model pm (.clk(clk), .rst(rst), .conv_en(conv_en),
    .pwm_out_en(pwm_out_en), .sense_bus(s_bus), .sense_u(s_u),
    .sense_v(s_v), .sense_w(s_w), .bus_volt_code(bus_volt_code),
    .cur_u_code(cur_u_code), .cur_v_code(cur_v_code),
    .cur_w_code(cur_w_code), .conversion_done_irq(conversion_done_irq));

  pim_ctrl #(.SPEED_TICK_CYCLES(50)) uut (.clk(clk), .rst(rst),
    .start_stop_switch(start_stop_switch), .cur_u_code(cur_u_code),
    .speed_reference_pot(speed_reference_pot), .cur_v_code(cur_v_code),
    .bus_volt_code(bus_volt_code), .cur_w_code(cur_w_code),
    .conversion_done_irq(conversion_done_irq), .vcmd_u(vcmd_u),
    .output_disable_event(output_disable_event), .vcmd_v(vcmd_v),
    .vcmd_w(vcmd_w), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_out_en(pwm_out_en), .compare_load(compare_load),
    .mod_wave_u(mod_wave_u), .mod_wave_v(mod_wave_v),
    .mod_wave_w(mod_wave_w), .mod_ratio(mod_ratio),
    .speed_tick_irq(speed_tick_irq), .speed_cmd_rpm(speed_cmd_rpm),
    .speed_dir_ccw(speed_dir_ccw), .system_mode(system_mode));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // Bounded wait for a load pulse (0) or a speed tick (1)
  task automatic wait_ev(input bit tick);
    int n;
    for (n = 0; n < 400; n++)
    begin
      @(negedge clk);
      if ((tick ? speed_tick_irq : compare_load) === 1'b1)
        break;
    end
    if (n == 400)
      chk(32'h0, 32'h1);
  endtask

  function automatic int cur_ma(int c);
    return c * 16500 / 4095 - 8250;
  endfunction

  function automatic int bus_cv(int c);
    return c * 7326 / 4095;
  endfunction

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 40000);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    int i, b, u, w, vu, vv, vw, mx, mn, off, pk, r;
    bit svm, two;
    logic [11:0] c;
    void'($urandom(85791));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(pim_pkg::REG_CTRL);
    chk(rd_val, 32'h0);
    rd(pim_pkg::REG_STATUS);
    chk(rd_val, 32'h0);
    rd(8'h20);
    chk(rd_val, 32'h0);
    $display("test registers done");
    @(posedge clk);
    conv_en <= 1'b1;
    start_stop_switch <= 1'b1;
    wait_ev(0);
    for (i = 0; i < 20; i++)
    begin
      svm = 1'($urandom);
      two = 1'($urandom);
      b = (i == 0) ? 448 : (i == 1) ? 3354 : 448 + $urandom % 2906;
      u = $urandom % 4096;
      w = $urandom % 4096;
      vu = int'($urandom % 6001) - 3000;
      vv = int'($urandom % 6001) - 3000;
      vw = (i == 2) ? vu : int'($urandom % 6001) - 3000;
      wr(pim_pkg::REG_CTRL, {30'h0, two, svm});
      @(posedge clk);
      s_bus <= 12'(b);
      s_u <= 12'(u);
      s_v <= 12'($urandom);
      s_w <= 12'(w);
      vcmd_u <= 16'(vu);
      vcmd_v <= 16'(vv);
      vcmd_w <= 16'(vw);
      wait_ev(0);
      mx = vu > vv ? (vu > vw ? vu : vw) : (vv > vw ? vv : vw);
      mn = vu < vv ? (vu < vw ? vu : vw) : (vv < vw ? vv : vw);
      off = svm ? (mx + mn) >>> 1 : 0;
      chk(mod_wave_u, 32'(vu - off));
      chk(mod_wave_v, 32'(vv - off));
      chk(mod_wave_w, 32'(vw - off));
      pk = (vu - off < 0) ? off - vu : vu - off;
      pk = (vv - off > pk) ? vv - off : (off - vv > pk) ? off - vv : pk;
      pk = (vw - off > pk) ? vw - off : (off - vw > pk) ? off - vw : pk;
      r = pk * 4096 / bus_cv(b);
      chk(mod_ratio, 32'(r > 65535 ? 65535 : r));
      chk(system_mode, 32'h1);
      chk(pwm_out_en, 32'h1);
      rd(pim_pkg::REG_BUS_V);
      chk(rd_val, 32'(bus_cv(b)));
      rd(pim_pkg::REG_CUR_U);
      chk(rd_val, {16'h0, 16'(cur_ma(u))});
      rd(pim_pkg::REG_CUR_V);
      if (two)
        chk(rd_val, {16'h0, 16'(-(cur_ma(u) + cur_ma(w)))});
      else
        chk(rd_val, {16'h0, 16'(cur_ma(int'(s_v)))});
      rd(pim_pkg::REG_CUR_W);
      chk(rd_val, {16'h0, 16'(cur_ma(w))});
    end
    $display("test modulation done");
    for (i = 0; i < 8; i++)
    begin
      c = (i < 4) ? 12'({12'h800, 12'hfff, 12'h7ff, 12'h000} >> (36 - 12 * i))
        : 12'($urandom);
      @(posedge clk);
      speed_reference_pot <= c;
      wait_ev(1);
      wait_ev(1);
      r = c[11] ? (c - 2048) * 2400 / 2047 : (2047 - c) * 2400 / 2047;
      chk(speed_cmd_rpm, 32'(r));
      chk(speed_dir_ccw, 32'(!c[11]));
      rd(pim_pkg::REG_SPEED);
      chk(rd_val, {15'h0, !c[11], 4'h0, 12'(r)});
    end
    $display("test speed done");
    @(posedge clk);
    start_stop_switch <= 1'b0;
    repeat (3) @(posedge clk);
    chk(system_mode, 32'h0);
    start_stop_switch <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pwm_out_en, 32'h1);
    output_disable_event <= 1'b1;
    @(negedge clk);
    chk(pwm_out_en, 32'h0);
    @(posedge clk);
    output_disable_event <= 1'b0;
    start_stop_switch <= 1'b0;
    rd(pim_pkg::REG_STATUS);
    chk(rd_val, 32'h6);
    start_stop_switch <= 1'b1;
    repeat (100) @(posedge clk);
    chk(system_mode, 32'h2);
    start_stop_switch <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      wr(pim_pkg::REG_CTRL, 32'h4);
      repeat (3) @(posedge clk);
      chk(system_mode, 32'h0);
      start_stop_switch <= 1'b1;
      s_bus <= i ? 12'd447 : 12'd3355;
      repeat (200) @(posedge clk);
      rd(pim_pkg::REG_STATUS);
      chk(rd_val, i ? 32'h12 : 32'h0a);
      s_bus <= 12'd2000;
      start_stop_switch <= 1'b0;
      repeat (200) @(posedge clk);
    end
    $display("test protection done");
    give_verdict();
  end
endmodule
